/* design/bertg_cfg.svh */
`ifndef BERTG_CFG_SVH
`define BERTG_CFG_SVH

// register byte offsets
`define BERTG_OFS_CTRL      8'h00
`define BERTG_OFS_PCFG      8'h04
`define BERTG_OFS_SEED      8'h08
`define BERTG_OFS_EINS      8'h0C
`define BERTG_OFS_STAT      8'h10
`define BERTG_OFS_SHIFT     8'h14

// tester_control_reg fields
`define BERTG_CTRL_EN       0
`define BERTG_CTRL_DIR      1
`define BERTG_CTRL_LOAD     2
`define BERTG_CTRL_INV      3
`define BERTG_CTRL_RXBIN    4
`define BERTG_CTRL_TXBIN    5

// pattern_config_reg fields
`define BERTG_PCFG_LEN_LSB  0
`define BERTG_PCFG_TAP_LSB  8
`define BERTG_PCFG_QRSS     16
`define BERTG_PCFG_REP      17

// tx_error_insert_ctrl_reg fields
`define BERTG_EINS_RATE_LSB 0
`define BERTG_EINS_SEN      3
`define BERTG_EINS_SWREQ    4

// status fields
`define BERTG_STAT_RUN      0
`define BERTG_STAT_PEND     1
`define BERTG_STAT_FULL     2
`define BERTG_STAT_BINERR   3

// reset values
`define BERTG_RST_LEN       6'h0F
`define BERTG_RST_TAP       6'h0E
`define BERTG_RST_SEED      32'hFFFF_FFFF

// fixed taps and widths of quasi-random mode
`define BERTG_QRSS_TAP_A    17
`define BERTG_QRSS_TAP_B    20
`define BERTG_QRSS_ZRUN     14

`endif

/* design/bertg_pkg.sv */
package bertg_pkg;

  typedef enum logic [1:0] {
    BERTG_MODE_PRBS,
    BERTG_MODE_REP,
    BERTG_MODE_QRSS
  } bertg_mode_t;

  typedef struct packed {
    logic enable;
    logic direction;
    logic invert;
    logic rx_binary;
    logic tx_binary;
  } bertg_ctrl_t;

  typedef struct packed {
    logic valid;
    logic data;
  } bertg_beat_t;

endpackage

/* design/bertg_top.sv */
// What this block does
// (R1) 32-bit shift register shifts bit 1 toward bit 32; feedback enters bit 1.
// (R2) pseudorandom feedback is bit n XOR bit y.
// (R3) repetitive feedback is bit n, so the pattern recirculates.
// (R4) length n and tap y are separate fields, 1 to 32, y below n.
// (R5) the feedback bit is the serial output bit.
// (R6) quasi-random: feedback bits 17 XOR 20; output one when 14 bits zero.
// (R7) pseudorandom and quasi-random force feedback one when bits 1-31 are zero.
// (R8) a new load puts the seed, masked to n bits, into the register.
// (R9) inversion control inverts every generated bit.
// (R10) rate insertion flips one bit in every 10^n, n from a 3-bit field.
// (R11) single-error enable allows one error per software or pin request.
// (R12) load happens on a 0-to-1 of the load bit, only while enabled.
// (R13) direction 0 feeds the line transmitter, 1 the system receive pins.
// (R14) pin rising edges between opportunities give one error only.
// (R15) data is binary NRZ; both binary selects must be set while enabled.
// (R16) rate code 0 disables insertion, codes 1 to 7 are the exponent.
`include "bertg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module bertg_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push, pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
    $error("bertg_fifo: DEPTH must be a power of two of at least 2");
  end

  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

module bertg_top
  import bertg_pkg::*;
#(
  parameter int BIT_DIV    = 1,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        manual_error_pin,
  input  wire logic        sink_ready,
  output bertg_beat_t      line_tx_q,
  output bertg_beat_t      sys_rx_q,
  output logic             tx_binary_select,
  output logic             rx_binary_select
);
  bertg_ctrl_t ctrl_q;
  logic        load_bit_q;
  logic [5:0]  len_q;
  logic [5:0]  tap_q;
  bertg_mode_t mode_q;
  logic [31:0] seed_q;
  logic [2:0]  rate_q;
  logic        sen_q;
  logic [31:0] sr_q;
  logic        pend_q, pin_q;
  logic [23:0] ecnt_q;
  logic [15:0] div_q;
  logic        tick, acc, wr_acc, load_req, sw_err, pin_rise, drain, err_d;
  logic        fb, gen_bit, rate_hit, gen;
  logic        fifo_in_ready, fifo_out_valid, fifo_out_data;
  logic [31:0] seed_mask;
  logic [31:0] rd_d;

  // the bit-time divider counts in 16 bits
  if (BIT_DIV < 1 || BIT_DIV > 65535) begin : g_bad_div
    $error("bertg_top: BIT_DIV must lie in 1..65535");
  end

  function automatic logic [23:0] rate_limit(input logic [2:0] code);
    case (code)
      3'h1:    rate_limit = 24'h00_0009;
      3'h2:    rate_limit = 24'h00_0063;
      3'h3:    rate_limit = 24'h00_03E7;
      3'h4:    rate_limit = 24'h00_270F;
      3'h5:    rate_limit = 24'h01_869F;
      3'h6:    rate_limit = 24'h0F_423F;
      default: rate_limit = 24'h98_967F;
    endcase
  endfunction
  // apb: registered answer, pready high during the first access cycle
  assign acc    = psel && penable && pready;
  assign wr_acc = acc && pwrite;

  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `BERTG_OFS_CTRL) begin
      rd_d[`BERTG_CTRL_EN]    = ctrl_q.enable;
      rd_d[`BERTG_CTRL_DIR]   = ctrl_q.direction;
      rd_d[`BERTG_CTRL_LOAD]  = load_bit_q;
      rd_d[`BERTG_CTRL_INV]   = ctrl_q.invert;
      rd_d[`BERTG_CTRL_RXBIN] = ctrl_q.rx_binary;
      rd_d[`BERTG_CTRL_TXBIN] = ctrl_q.tx_binary;
    end else if (paddr == `BERTG_OFS_PCFG) begin
      rd_d[`BERTG_PCFG_LEN_LSB +: 6] = len_q;
      rd_d[`BERTG_PCFG_TAP_LSB +: 6] = tap_q;
      rd_d[`BERTG_PCFG_QRSS]         = (mode_q == BERTG_MODE_QRSS);
      rd_d[`BERTG_PCFG_REP]          = (mode_q == BERTG_MODE_REP);
    end else if (paddr == `BERTG_OFS_SEED) begin
      rd_d = seed_q;
    end else if (paddr == `BERTG_OFS_EINS) begin
      rd_d[`BERTG_EINS_RATE_LSB +: 3] = rate_q;
      rd_d[`BERTG_EINS_SEN]           = sen_q;
    end else if (paddr == `BERTG_OFS_STAT) begin
      rd_d[`BERTG_STAT_RUN]    = ctrl_q.enable;
      rd_d[`BERTG_STAT_PEND]   = pend_q;
      rd_d[`BERTG_STAT_FULL]   = !fifo_in_ready;
      rd_d[`BERTG_STAT_BINERR] = ctrl_q.enable && !(ctrl_q.rx_binary && ctrl_q.tx_binary); // [R15]
    end else if (paddr == `BERTG_OFS_SHIFT) begin
      rd_d = sr_q;
    end else begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
      pslverr <= psel && !penable && err_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q     <= '0;
      load_bit_q <= 1'b0;
    end else if (wr_acc && paddr == `BERTG_OFS_CTRL) begin
      ctrl_q.enable    <= pwdata[`BERTG_CTRL_EN];
      ctrl_q.direction <= pwdata[`BERTG_CTRL_DIR];
      ctrl_q.invert    <= pwdata[`BERTG_CTRL_INV];
      ctrl_q.rx_binary <= pwdata[`BERTG_CTRL_RXBIN];
      ctrl_q.tx_binary <= pwdata[`BERTG_CTRL_TXBIN];
      load_bit_q       <= pwdata[`BERTG_CTRL_LOAD];
    end
  end
  // enable written in the same access counts, so enable-and-load works in one write
  assign load_req = wr_acc && paddr == `BERTG_OFS_CTRL && pwdata[`BERTG_CTRL_LOAD]
                    && !load_bit_q && pwdata[`BERTG_CTRL_EN]; // [R12]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      len_q  <= `BERTG_RST_LEN;
      tap_q  <= `BERTG_RST_TAP;
      mode_q <= BERTG_MODE_PRBS;
    end else if (wr_acc && paddr == `BERTG_OFS_PCFG) begin
      len_q  <= pwdata[`BERTG_PCFG_LEN_LSB +: 6]; // [R4]
      tap_q  <= pwdata[`BERTG_PCFG_TAP_LSB +: 6]; // [R4]
      if (pwdata[`BERTG_PCFG_QRSS]) begin
        mode_q <= BERTG_MODE_QRSS;
      end else if (pwdata[`BERTG_PCFG_REP]) begin
        mode_q <= BERTG_MODE_REP;
      end else begin
        mode_q <= BERTG_MODE_PRBS;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seed_q <= `BERTG_RST_SEED;
    end else if (wr_acc && paddr == `BERTG_OFS_SEED) begin
      seed_q <= pwdata;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_q <= 3'h0;
      sen_q  <= 1'b0;
    end else if (wr_acc && paddr == `BERTG_OFS_EINS) begin
      rate_q <= pwdata[`BERTG_EINS_RATE_LSB +: 3];
      sen_q  <= pwdata[`BERTG_EINS_SEN];
    end
  end
  // bit-time enable
  always_ff @(posedge clk) begin
    if (!rst_n || div_q == 16'(BIT_DIV - 1)) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign tick = (div_q == 16'(BIT_DIV - 1));

  // pattern generator; a full fifo stalls it so no bit is dropped, but a load flushes the bits still queued in the fifo
  always_comb begin
    if (mode_q == BERTG_MODE_QRSS) begin
      fb = sr_q[`BERTG_QRSS_TAP_A-1] ^ sr_q[`BERTG_QRSS_TAP_B-1]; // [R6]
    end else if (mode_q == BERTG_MODE_REP) begin
      fb = sr_q[5'(len_q - 6'd1)]; // [R3]
    end else begin
      fb = sr_q[5'(len_q - 6'd1)] ^ sr_q[5'(tap_q - 6'd1)]; // [R2]
    end
    if (mode_q != BERTG_MODE_REP && sr_q[30:0] == 31'h0000_0000) begin
      fb = 1'b1; // [R7]
    end
  end

  assign seed_mask = (len_q >= 6'd32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << len_q) - 32'h0000_0001);
  assign gen       = ctrl_q.enable && !load_req && fifo_in_ready;
  assign rate_hit  = (rate_q != 3'h0) && (ecnt_q >= rate_limit(rate_q)); // [R16]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sr_q <= 32'h0000_0000;
    end else if (load_req) begin
      sr_q <= seed_q & seed_mask; // [R8]
    end else if (gen) begin
      sr_q <= {sr_q[30:0], fb}; // [R1]
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || rate_q == 3'h0 || load_req) begin
      ecnt_q <= 24'h00_0000;
    end else if (gen) begin
      ecnt_q <= rate_hit ? 24'h00_0000 : ecnt_q + 24'h00_0001; // [R10]
    end
  end
  // single error: request edges collapse into one pending flag; a new
  // request arriving as the flag is consumed keeps it set
  assign sw_err   = wr_acc && paddr == `BERTG_OFS_EINS && pwdata[`BERTG_EINS_SWREQ];
  assign pin_rise = manual_error_pin && !pin_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_q  <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      pin_q <= manual_error_pin;
      if (sen_q && (sw_err || pin_rise)) begin
        pend_q <= 1'b1; // [R11] [R14]
      end else if (gen || !sen_q) begin
        pend_q <= 1'b0; // [R14]
      end
    end
  end

  always_comb begin
    gen_bit = fb; // [R5]
    if (mode_q == BERTG_MODE_QRSS && sr_q[`BERTG_QRSS_ZRUN-1:0] == 14'h0000) begin
      gen_bit = 1'b1; // [R6]
    end
    gen_bit = gen_bit ^ ctrl_q.invert ^ rate_hit ^ pend_q; // [R9] [R10] [R11]
  end

  bertg_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n && !load_req),
    .in_valid  (gen),
    .in_data   (gen_bit),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (drain)
  );
  assign drain = tick && sink_ready;

  // one beat per bit time toward the side picked by the direction bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_tx_q <= '0;
      sys_rx_q  <= '0;
    end else if (drain) begin
      line_tx_q.valid <= fifo_out_valid && !ctrl_q.direction; // [R13]
      line_tx_q.data  <= fifo_out_data && !ctrl_q.direction;
      sys_rx_q.valid  <= fifo_out_valid && ctrl_q.direction; // [R13]
      sys_rx_q.data   <= fifo_out_data && ctrl_q.direction;
    end else begin
      line_tx_q.valid <= 1'b0;
      sys_rx_q.valid  <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_binary_select <= 1'b0;
      rx_binary_select <= 1'b0;
    end else begin
      tx_binary_select <= ctrl_q.tx_binary; // [R15]
      rx_binary_select <= ctrl_q.rx_binary; // [R15]
    end
  end
endmodule

`default_nettype wire

/* dv/bertg_top_asserts.sv */
`include "bertg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module bertg_top_asserts
  import bertg_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        manual_error_pin,
  input wire logic        sink_ready,
  input wire bertg_beat_t line_tx_q,
  input wire bertg_beat_t sys_rx_q,
  input wire logic        tx_binary_select,
  input wire logic        rx_binary_select
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic wc;
  assign wc = psel && penable && pready && pwrite && paddr == `BERTG_OFS_CTRL;

  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_rdata_idle: assert property (!pready |-> prdata == 0)
    else $error("read data outside answer");
  a_slverr_unmapped: assert property (pready && paddr > `BERTG_OFS_SHIFT |-> pslverr)
    else $error("unmapped not refused");
  a_slverr_mapped: assert property (pready && paddr <= `BERTG_OFS_SHIFT && paddr[1:0] == 0
    |-> !pslverr) else $error("mapped refused");
  a_txbin_follow: assert property (wc |-> ##2 tx_binary_select == $past(pwdata[5], 2))
    else $error("tx binary select wrong");
  a_rxbin_follow: assert property (wc |-> ##2 rx_binary_select == $past(pwdata[4], 2))
    else $error("rx binary select wrong");
  a_beat_ready: assert property (line_tx_q.valid || sys_rx_q.valid |-> $past(sink_ready))
    else $error("beat without sink ready");
  a_one_side: assert property (!(line_tx_q.valid && sys_rx_q.valid))
    else $error("both directions active");

  cover property (wc);
  cover property (line_tx_q.valid);
  cover property (sys_rx_q.valid);
  cover property (pready && pslverr);
endmodule

bind bertg_top bertg_top_asserts chk_i (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .manual_error_pin(manual_error_pin), .sink_ready(sink_ready),
  .line_tx_q(line_tx_q), .sys_rx_q(sys_rx_q), .tx_binary_select(tx_binary_select),
  .rx_binary_select(rx_binary_select));
`default_nettype wire

/* dv/bertg_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module bertg_sink
  import bertg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire bertg_beat_t tx,
  input  wire bertg_beat_t rx,
  output logic             rdy
);
  logic qt[$];
  logic qr[$];
  // stall models a slow consumer so the fifo can back up
  assign rdy = !stall;
  always @(posedge clk) begin
    if (tx.valid)
      qt.push_back(tx.data);
    if (rx.valid)
      qr.push_back(rx.data);
  end
endmodule
`default_nettype wire

/* dv/bertg_tb_top.sv */
`include "bertg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module bertg_tb_top;
  import bertg_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pin, stall, rdy;
  logic        pready, pslverr, er, txb, rxb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, sd;
  bertg_beat_t ltx, srx;
  int          err_total, check_count, cyc, n, y, md, inv, rt;
  logic        e[$];

  bertg_top uut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .manual_error_pin(pin), .sink_ready(rdy), .line_tx_q(ltx), .sys_rx_q(srx),
    .tx_binary_select(txb), .rx_binary_select(rxb));
  bertg_sink s (.clk(clk), .stall(stall), .tx(ltx), .rx(srx), .rdy(rdy));

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop;
    end
  end

  task report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(string nm, logic [31:0] ex, logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, ex, got);
    end
  endtask

  // holds the request until pready is seen high at a rising edge
  task xfer(logic [7:0] a, logic [31:0] d, logic w);
    int k;
    paddr   <= a;
    pwdata  <= d;
    pwrite  <= w;
    psel    <= 1;
    penable <= 0;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1 && k < 50);
    if (k >= 50)
      chk("pready wait", 1, 0);
    rd = prdata;
    er = pslverr;
    psel    <= 0;
    penable <= 0;
    // one idle edge, so a following call never reassigns psel in this time step
    @(posedge clk);
  endtask

  task mk(int cnt);
    logic [31:0] r;
    logic        f, o;
    int          p;
    r = sd & ((32'h1 << n) - 1);
    p = 10 ** rt;
    e = {};
    for (int i = 1; i <= cnt; i++) begin
      f = md == 1 ? r[n-1] : md == 2 ? r[16] ^ r[19] : r[n-1] ^ r[y-1];
      if (md != 1 && r[30:0] == 0)
        f = 1;
      o = (md == 2 && r[13:0] == 0) ? 1'b1 : f;
      r = {r[30:0], f};
      e.push_back(o ^ inv[0] ^ (rt != 0 && i % p == 0));
    end
  endtask

  task go(int m, int nn, int yy, logic [31:0] seed, int iv, int dir, int r, int se);
    int   k, d;
    logic q[$];
    md = m;
    n = nn;
    y = yy;
    sd = seed;
    inv = iv;
    rt = r;
    xfer(`BERTG_OFS_CTRL, 32'h30, 1);
    repeat (40) @(posedge clk);
    s.qt = {};
    s.qr = {};
    xfer(`BERTG_OFS_PCFG, {14'h0, m == 1, m == 2, 2'h0, 6'(yy), 2'h0, 6'(nn)}, 1);
    xfer(`BERTG_OFS_SEED, seed, 1);
    xfer(`BERTG_OFS_EINS, 32'(r) | 32'(se != 0) << 3, 1);
    xfer(`BERTG_OFS_CTRL, 32'h35 | 32'(iv) << 3 | 32'(dir) << 1, 1);
    if (se != 0) begin
      stall <= 1;
      repeat (60) @(posedge clk);
      xfer(`BERTG_OFS_STAT, 0, 0);
      chk("fifo full", 32'h5, rd);
      if (se == 1) begin
        repeat (2) begin
          pin <= 1;
          @(posedge clk);
          pin <= 0;
          @(posedge clk);
        end
      end else
        xfer(`BERTG_OFS_EINS, 32'h18, 1);
      xfer(`BERTG_OFS_STAT, 0, 0);
      chk("pending", 32'h7, rd);
      stall <= 0;
    end
    k = 0;
    while (s.qt.size() + s.qr.size() < 200 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    mk(200);
    if (dir)
      q = s.qr;
    else
      q = s.qt;
    d = 0;
    for (int i = 0; i < 200; i++)
      d += (q[i] !== e[i]);
    chk("bit errors", 32'(se != 0), 32'(d));
    chk("idle side", 0, 32'(dir ? s.qt.size() : s.qr.size()));
  endtask

  initial begin
    rst_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pin = 0;
    stall = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    xfer(`BERTG_OFS_PCFG, 0, 0);
    chk("len tap reset", 32'h0E0F, rd);
    xfer(`BERTG_OFS_SEED, 0, 0);
    chk("seed reset", 32'hFFFF_FFFF, rd);
    xfer(`BERTG_OFS_STAT, 32'hF, 1);
    xfer(`BERTG_OFS_STAT, 0, 0);
    chk("status ro", 0, rd);
    xfer(8'h40, 32'h1, 1);
    chk("unmapped err", 1, 32'(er));
    xfer(`BERTG_OFS_CTRL, 32'h34, 1);
    xfer(`BERTG_OFS_SHIFT, 0, 0);
    chk("load while disabled", 0, rd);
    xfer(`BERTG_OFS_CTRL, 32'h1, 1);
    xfer(`BERTG_OFS_STAT, 0, 0);
    chk("binary select missing", 32'h9, rd);
    go(0, 15, 14, 32'hFFFF_1234, 0, 0, 0, 0);
    go(0, 7, 6, 0, 0, 0, 0, 0);
    go(0, 32, 22, 32'hFFFF_FFFF, 0, 0, 0, 0);
    go(1, 8, 1, 32'h00A5, 0, 0, 0, 0);
    go(2, 20, 17, 0, 0, 0, 0, 0);
    go(0, 15, 14, 32'h0001, 1, 1, 0, 0);
    for (int r = 0; r < 8; r++)
      go(0, 11, 9, 32'h0055, 0, 0, r, 0);
    go(0, 15, 14, 32'h0077, 0, 0, 0, 1);
    go(0, 15, 14, 32'h0077, 0, 1, 0, 2);
    report_and_stop;
  end
endmodule
`default_nettype wire
